// *** sapi_top.sv ***
// conversion control and parallel read port of the sampling converter
// Contract
// (RQ1) low convert start with chip select starts
// (RQ2) starts ignored while converting
// (RQ3) busy low during conversion, high after
// (RQ4) conversion lasts 1.6 us internally
// (RQ5) host allows 250 ns acquisition
// (RQ6) low power-down input powers down
// (RQ7) no conversion while powered down
// (RQ8) ready 350 ns after power-down release
// (RQ9) tied-low selects keep outputs driven
// (RQ10) falling convert start edge triggers
// (RQ11) outputs float until read strobe
// (RQ12) tied strobe starts, shows previous result
// (RQ13) new result and busy high at end
// (RQ14) rom strobe starts and presents previous
// (RQ15) host waits completion before rereading
// (RQ16) unipolar codes are straight binary
// (RQ17) bipolar codes cross zero at all ones
// (RQ18) host stalls or buffers bus
// (RQ19) result latched at conversion end
// (RQ20) bipolar output is two's complement
// (RQ21) drive data only with select and read low
`timescale 1ns/1ns
module sapi_top
    import sapi_pkg::*;
#(
    parameter int DATA_WIDTH = SAPI_DATA_WIDTH
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic convert_start_n,
    input wire logic power_down_n,
    input wire logic bipolar,
    input wire logic [11:0] analog_code,
    output logic busy_n,
    output logic [11:0] data_out,
    output logic [11:0] data_oe_n
);
    // refuse word widths the fixed 12-bit datapath cannot serve
    if (DATA_WIDTH != SAPI_DATA_WIDTH) begin : g_width_check
        $error("only a 12-bit word is supported");
    end

    logic [4:0] sync1;
    logic [4:0] sync2;
    logic cs_s;
    logic rd_s;
    logic cv_s;
    logic pd_s;
    logic bp_s;
    logic cv_prev;
    logic [11:0] ain1;
    logic [11:0] ain2;
    sapi_state_type state;
    logic [SAPI_CNT_WIDTH-1:0] count;
    logic start_edge;
    logic conv_end;
    logic [11:0] result;
    sapi_sar_if sar();

    // pin synchronisers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 5'h0F;
            sync2 <= 5'h0F;
            ain1 <= 12'h000;
            ain2 <= 12'h000;
        end else begin
            sync1 <= {bipolar, power_down_n, convert_start_n, read_n, chip_select_n};
            sync2 <= sync1;
            ain1 <= analog_code;
            ain2 <= ain1;
        end
    end

    assign cs_s = sync2[0];
    assign rd_s = sync2[1];
    assign cv_s = sync2[2];
    assign pd_s = sync2[3];
    assign bp_s = sync2[4];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cv_prev <= 1'b1;
        end else begin
            cv_prev <= cv_s;
        end
    end

    // falling edge of convert start while selected
    assign start_edge = cv_prev && !cv_s && !cs_s; // RQ1 RQ10

    // conversion sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SAPI_WAKE;
            count <= '0;
        end else if (!pd_s) begin
            state <= SAPI_OFF; // RQ6 RQ7
            count <= '0;
        end else begin
            unique case (state)
                SAPI_OFF: begin
                    state <= SAPI_WAKE;
                    count <= '0;
                end
                SAPI_WAKE: begin
                    if (count == SAPI_CNT_WIDTH'(SAPI_WAKE_CYCLES - 1)) begin
                        state <= SAPI_IDLE; // RQ8
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                SAPI_IDLE: begin
                    if (start_edge) begin
                        state <= SAPI_CONV; // RQ1
                        count <= '0;
                    end
                end
                SAPI_CONV: begin
                    // starts ignored until the count ends
                    if (count == SAPI_CNT_WIDTH'(SAPI_CONV_CYCLES - 1)) begin
                        state <= SAPI_IDLE; // RQ2 RQ4
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
            endcase
        end
    end

    assign sar.start = (state == SAPI_IDLE) && pd_s && start_edge;
    // last counted cycle of a conversion that was not aborted
    assign conv_end = pd_s && state == SAPI_CONV &&
        count == SAPI_CNT_WIDTH'(SAPI_CONV_CYCLES - 1);
    assign sar.bipolar = bp_s; // RQ16 RQ17
    assign sar.sample = ain2;

    sapi_sar u_sar (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sar(sar)
    );

    // output latch loads at conversion end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result <= SAPI_RESULT_RESET;
        end else if (conv_end) begin
            result <= sar.result; // RQ19 RQ13
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_n <= 1'b1;
        end else begin
            busy_n <= !((pd_s && state == SAPI_CONV && !conv_end) || sar.start); // RQ3 RQ12
        end
    end

    // data latch shown on the pins, new word at conversion end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= SAPI_RESULT_RESET;
        end else begin
            data_out <= conv_end ? sar.result : result; // RQ14 RQ12
        end
    end

    // drivers on only with select and read low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_oe_n <= 12'hFFF;
        end else begin
            data_oe_n <= {12{cs_s | rd_s}}; // RQ21 RQ11 RQ9
        end
    end

    AST_BUSY_LOW_ON_START: assert property ( // RQ3
        @(posedge core_clk) disable iff (!arst_n)
        sar.start |=> !busy_n)
        else $error("busy not low after start");
    AST_CONV_LENGTH: assert property ( // RQ4
        @(posedge core_clk) disable iff (!arst_n)
        sar.start |=> !busy_n [*8])
        else $error("busy rose early");
    AST_CONV_ENDS: assert property ( // RQ4
        @(posedge core_clk) disable iff (!arst_n)
        sar.start |-> ##[1:201] busy_n)
        else $error("conversion did not end");
    AST_CONV_FULL: assert property ( // RQ3 RQ4
        @(posedge core_clk) disable iff (!arst_n)
        conv_end |=> busy_n && state == SAPI_IDLE)
        else $error("busy not released at conversion end");
    AST_NO_RESTART: assert property ( // RQ2
        @(posedge core_clk) disable iff (!arst_n)
        pd_s && state == SAPI_CONV && !conv_end |=>
        state == SAPI_CONV && count == $past(count) + 1'b1)
        else $error("restart during conversion");
    AST_OFF_NO_START: assert property ( // RQ6 RQ7
        @(posedge core_clk) disable iff (!arst_n)
        !pd_s |=> state == SAPI_OFF && busy_n)
        else $error("active in power down");
    AST_WAKE_BOUND: assert property ( // RQ8
        @(posedge core_clk) disable iff (!arst_n)
        $rose(pd_s) |-> ##[1:46] state == SAPI_IDLE || !pd_s)
        else $error("wake took too long");
    AST_WAKE_NOT_EARLY: assert property ( // RQ8
        @(posedge core_clk) disable iff (!arst_n)
        $rose(pd_s) |=> (state == SAPI_WAKE || state == SAPI_OFF) [*8])
        else $error("idle too soon after power up");
    AST_START_NEEDS_CS: assert property ( // RQ1 RQ10
        @(posedge core_clk) disable iff (!arst_n)
        sar.start |-> !cs_s && $fell(cv_s))
        else $error("start without select");
    AST_OE_FOLLOWS: assert property ( // RQ21
        @(posedge core_clk) disable iff (!arst_n)
        !cs_s && !rd_s |=> data_oe_n == 12'h000)
        else $error("outputs not driven");
    AST_OE_FLOATS: assert property ( // RQ11
        @(posedge core_clk) disable iff (!arst_n)
        rd_s |=> data_oe_n == 12'hFFF)
        else $error("outputs driven without read");
    AST_OE_UNIFORM: assert property ( // RQ21
        @(posedge core_clk) disable iff (!arst_n)
        data_oe_n == 12'h000 || data_oe_n == 12'hFFF)
        else $error("output enables split");
    AST_RESULT_AT_END: assert property ( // RQ19 RQ13
        @(posedge core_clk) disable iff (!arst_n)
        $rose(busy_n) |-> data_out == result)
        else $error("result missing at end");
    AST_RESULT_LOAD: assert property ( // RQ19
        @(posedge core_clk) disable iff (!arst_n)
        conv_end |=> result == $past(sar.result))
        else $error("latch missed the new word");
    AST_RESULT_HELD: assert property ( // RQ12 RQ14
        @(posedge core_clk) disable iff (!arst_n)
        !busy_n |=> busy_n || $stable(result))
        else $error("latch changed during conversion");
    AST_SAR_DONE: assert property ( // RQ19
        @(posedge core_clk) disable iff (!arst_n)
        sar.start |-> ##12 sar.done)
        else $error("bit search did not finish in twelve steps");
endmodule

// *** sapi_pkg.sv ***
// shared constants for the sampling converter parallel interface
package sapi_pkg;
    localparam int SAPI_DATA_WIDTH = 12;
    localparam int SAPI_CLK_PERIOD_NS = 8;
    localparam int SAPI_CONV_TIME_NS = 1600;
    localparam int SAPI_WAKE_TIME_NS = 350;
    localparam int SAPI_ACQ_TIME_NS = 250;
    localparam int SAPI_CONV_CYCLES = SAPI_CONV_TIME_NS / SAPI_CLK_PERIOD_NS;
    localparam int SAPI_WAKE_CYCLES = (SAPI_WAKE_TIME_NS + SAPI_CLK_PERIOD_NS - 1)
        / SAPI_CLK_PERIOD_NS;
    localparam int SAPI_CNT_WIDTH = 8;
    localparam logic [11:0] SAPI_RESULT_RESET = 12'h000;
    typedef enum logic [1:0] {
        SAPI_OFF  = 2'b00,
        SAPI_WAKE = 2'b01,
        SAPI_IDLE = 2'b10,
        SAPI_CONV = 2'b11
    } sapi_state_type;
endpackage

// *** sapi_sar_if.sv ***
// handshake between sequencer and successive-approximation core
`timescale 1ns/1ns
interface sapi_sar_if;
    logic start;
    logic bipolar;
    logic [11:0] sample;
    logic done;
    logic [11:0] result;
    modport ctrl (output start, output bipolar, output sample, input done, input result);
    modport core (input start, input bipolar, input sample, output done, output result);
endinterface

// *** sapi_sar.sv ***
// bit-serial successive-approximation core, msb first
`timescale 1ns/1ns
module sapi_sar
    import sapi_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    sapi_sar_if.core sar
);
    logic [11:0] trial;
    logic [11:0] mask;
    logic [11:0] held;
    logic running;
    logic [11:0] code;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trial <= 12'h000;
            mask <= 12'h000;
            held <= 12'h000;
            running <= 1'b0;
        end else if (sar.start) begin
            held <= sar.sample;
            trial <= 12'h800;
            mask <= 12'h800;
            running <= 1'b1;
        end else if (running) begin
            if (trial > held) begin
                trial <= (trial & ~mask) | (mask >> 1);
            end else begin
                trial <= trial | (mask >> 1);
            end
            mask <= mask >> 1;
            if (mask == 12'h001) begin
                running <= 1'b0;
            end
        end
    end

    // bipolar output is two's complement
    always_comb begin
        code = trial;
        if (sar.bipolar) begin
            code = {~trial[11], trial[10:0]}; // RQ20 RQ17
        end
    end

    assign sar.result = code;
    assign sar.done = running && (mask == 12'h001);
endmodule

// *** sapi_host.sv ***
// host model driving the converter control pins
`timescale 1ns/1ns
module sapi_host (
    input wire logic core_clk,
    input wire logic busy_n,
    output logic chip_select_n,
    output logic read_n,
    output logic convert_start_n,
    output logic power_down_n
);
    initial begin
        chip_select_n = 1'b0;
        read_n = 1'b0;
        convert_start_n = 1'b1;
        power_down_n = 1'b1;
    end
    bit idle_low = 1'b0;
    // narrow low pulse, held low with the read strobe when tied, or narrow high pulse when idling low
    task automatic conv(input bit tie);
        if (idle_low) begin
            @(posedge core_clk);
            convert_start_n <= 1'b1;
            repeat (2) @(posedge core_clk);
        end
        @(posedge core_clk);
        convert_start_n <= 1'b0;
        if (tie) read_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        if (!tie && !idle_low) convert_start_n <= 1'b1;
    endtask
    // wait for busy high, release strobe, acquisition gap
    task automatic fin(input bit tie);
        int n = 0;
        while (busy_n !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        if (!idle_low) convert_start_n <= 1'b1;
        if (tie) read_n <= 1'b1;
        repeat (32) @(posedge core_clk);
    endtask
    task automatic pins(input logic cs, input logic rd, input logic pd);
        @(posedge core_clk);
        chip_select_n <= cs;
        read_n <= rd;
        power_down_n <= pd;
    endtask
    // idle level of convert start: low for high-going pulses
    task automatic style(input bit low);
        @(posedge core_clk);
        idle_low = low;
        convert_start_n <= !low;
    endtask
endmodule

// *** sampling_adc_parallel_interface_test.sv ***
// self-checking bench for the converter control and read port
`timescale 1ns/1ns
module sampling_adc_parallel_interface_test;
    import sapi_pkg::*;
    logic core_clk, arst_n, cs_n, rd_n, cv_n, pd_n, bipolar, busy_n;
    logic [11:0] analog_code, data_out, data_oe_n;
    logic [11:0] last = SAPI_RESULT_RESET;
    int error_cnt = 0;
    int checked = 0;
    sapi_top sapi_top_i (.core_clk(core_clk), .arst_n(arst_n), .chip_select_n(cs_n),
        .read_n(rd_n), .convert_start_n(cv_n), .power_down_n(pd_n), .bipolar(bipolar),
        .analog_code(analog_code), .busy_n(busy_n), .data_out(data_out),
        .data_oe_n(data_oe_n));
    sapi_host sapi_host_i (.core_clk(core_clk), .busy_n(busy_n), .chip_select_n(cs_n),
        .read_n(rd_n), .convert_start_n(cv_n), .power_down_n(pd_n));
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
        checked++;
        if (e !== s) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic run(input logic [11:0] c, input logic b, input logic [11:0] e,
        input bit tie, input logic [11:0] blen);
        int len = 0;
        @(posedge core_clk);
        analog_code <= c;
        bipolar <= b;
        repeat (3) @(posedge core_clk);
        fork
            sapi_host_i.conv(tie);
            begin
                for (int i = 0; i < 12 && busy_n !== 1'b0; i++) @(negedge core_clk);
                if (busy_n === 1'b0) begin
                    chk("held", last, data_out);
                    chk("oe", 12'h000, data_oe_n);
                end
                while (busy_n === 1'b0 && len < 400) begin
                    @(negedge core_clk);
                    len++;
                end
            end
        join
        chk("busy_len", blen, len[11:0]);
        if (blen != 0) begin
            chk("result", e, data_out);
            last = e;
        end
        sapi_host_i.fin(tie);
    endtask
    task automatic t_uni();
        run(12'hFFF, 1'b0, 12'hFFF, 0, 12'd200);
        run(12'h000, 1'b0, 12'h000, 0, 12'd200);
        run(12'h5A3, 1'b0, 12'h5A3, 0, 12'd200);
    endtask
    task automatic t_bip();
        run(12'h800, 1'b1, 12'h000, 0, 12'd200);
        run(12'h7FF, 1'b1, 12'hFFF, 0, 12'd200);
        run(12'hFFF, 1'b1, 12'h7FF, 0, 12'd200);
    endtask
    task automatic t_restart();
        fork
            run(12'h123, 1'b0, 12'h123, 0, 12'd200);
            begin
                repeat (60) @(posedge core_clk);
                analog_code <= 12'h456;
                sapi_host_i.conv(0);
            end
        join
    endtask
    task automatic t_sel();
        sapi_host_i.pins(1'b1, 1'b0, 1'b1);
        run(12'h321, 1'b0, 12'h000, 0, 12'd0);
        @(negedge core_clk);
        chk("oe_cs", 12'hFFF, data_oe_n);
        sapi_host_i.pins(1'b0, 1'b1, 1'b1);
        repeat (5) @(negedge core_clk);
        chk("oe_rd", 12'hFFF, data_oe_n);
        sapi_host_i.pins(1'b0, 1'b0, 1'b1);
        repeat (5) @(negedge core_clk);
        chk("oe_on", 12'h000, data_oe_n);
    endtask
    task automatic t_pd();
        sapi_host_i.pins(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk);
        run(12'h2B4, 1'b0, 12'h000, 0, 12'd0);
        sapi_host_i.pins(1'b0, 1'b0, 1'b1);
        repeat (48) @(posedge core_clk);
        run(12'h777, 1'b0, 12'h777, 0, 12'd200);
    endtask
    task automatic t_slow();
        sapi_host_i.pins(1'b0, 1'b1, 1'b1);
        run(12'hABC, 1'b0, 12'hABC, 1, 12'd200);
        run(12'hDEF, 1'b0, 12'hDEF, 1, 12'd200);
    endtask
    task automatic t_hi();
        sapi_host_i.pins(1'b1, 1'b0, 1'b1);
        sapi_host_i.style(1'b1);
        repeat (3) @(posedge core_clk);
        sapi_host_i.pins(1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge core_clk);
        run(12'h3C5, 1'b0, 12'h3C5, 0, 12'd200);
        sapi_host_i.style(1'b0);
    endtask
    task automatic end_sim();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #(20000 * 8);
        error_cnt++;
        end_sim();
    end
    initial begin
        arst_n = 1'b0;
        analog_code = 12'h000;
        bipolar = 1'b0;
        repeat (5) @(posedge core_clk);
        chk("rst_oe", 12'hFFF, data_oe_n);
        arst_n <= 1'b1;
        repeat (50) @(posedge core_clk);
        t_uni();
        t_bip();
        t_restart();
        t_sel();
        t_pd();
        t_slow();
        t_hi();
        end_sim();
    end
endmodule
